//--- inc/hms_pkg.sv
// Purpose: shared constants and types of the halt mode sequencer
// Assumes: one clock, clk_sys, synchronous active low reset
// Notes:   register offsets are byte addresses on the plain port
package hms_pkg;

  // ----------------------------------------------------------------
  // interrupt lines and wake capability
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 14;
  // line 1 is the clock_timebase_counter / clock_security_irq vector
  localparam int TIMEBASE_IRQ_LINE = 1;
  localparam logic [13:0] WAKE_TIMED_MASK = 14'h111E;
  localparam logic [13:0] WAKE_FULL_MASK = 14'h111C;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;
  localparam logic [3:0] CLOCK_CTRL_STATUS_REG_OFS = 4'h0;
  localparam logic [3:0] HALT_STATUS_REG_OFS = 4'h1;
  localparam int OSC_IRQ_ENABLE_BIT = 0;
  localparam int STAB_LONG_BIT = 1;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_BY_RESET_BIT = 4;
  localparam logic [7:0] REG_READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // mask level and stabilisation counts, in cpu cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] CCR_MASK_HALT = 2'b10;
  localparam int STAB_CNT_W = 13;
  localparam logic [12:0] STAB_SHORT_CYC = 13'h0100;
  localparam logic [12:0] STAB_LONG_CYC = 13'h1000;

  // ----------------------------------------------------------------
  // state and register types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    HMS_RUN = 4'b0001,
    HMS_TIMED = 4'b0010,
    HMS_FULL = 4'b0100,
    HMS_STAB = 4'b1000
  } hms_state_type;

  typedef struct packed {
    hms_state_type state;
    logic oscIrqEnable;
    logic stabLong;
    logic captured;
    logic byReset;
    logic [7:0] rdata;
    logic cpuClkEn;
    logic periphClkEn;
    logic oscEn;
    logic timebaseClkEn;
    logic ccrMaskWr;
    logic [1:0] ccrMaskVal;
    logic ccrPush;
    logic serviceIrq;
    logic fetchVector;
    logic wdogResetReq;
    logic [12:0] stabSeen;
  } hms_regs_type;

  localparam hms_regs_type HMS_REGS_RESET = '{
    state: HMS_RUN,
    oscIrqEnable: 1'b0,
    stabLong: 1'b0,
    captured: 1'b0,
    byReset: 1'b0,
    rdata: 8'h00,
    cpuClkEn: 1'b1,
    periphClkEn: 1'b1,
    oscEn: 1'b1,
    timebaseClkEn: 1'b1,
    ccrMaskWr: 1'b0,
    ccrMaskVal: 2'b00,
    ccrPush: 1'b0,
    serviceIrq: 1'b0,
    fetchVector: 1'b0,
    wdogResetReq: 1'b0,
    stabSeen: 13'h0000
  };

endpackage

//--- src/hms_sequencer.sv
// Purpose: timed halt and full halt sequencing for the cpu core
// Assumes: haltExec, irqPend, irqPrio and watchdog inputs on clk_sys
// Notes:   rstReqPin and stabLongPin are asynchronous pins
`timescale 1ns/100ps
module hms_sequencer import hms_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic haltExec,
  input wire logic [13:0] irqPend,
  input wire logic [1:0] irqPrio,
  input wire logic rstReqPin,
  input wire logic stabLongPin,
  input wire logic wdogActive,
  input wire logic wdogOnHaltOption,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic oscEn,
  output logic timebaseClkEn,
  output logic ccrMaskWr,
  output logic [1:0] ccrMaskVal,
  output logic ccrPush,
  output logic serviceIrq,
  output logic fetchResetVector,
  output logic wdogResetReq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic rstReqSync;
  logic stabLongSync;

  hms_sync2 u_rst_sync (
    .clk_sys(clk_sys),
    .pinIn(rstReqPin),
    .syncOut(rstReqSync)
  );

  hms_sync2 u_long_sync (
    .clk_sys(clk_sys),
    .pinIn(stabLongPin),
    .syncOut(stabLongSync)
  );

  // ----------------------------------------------------------------
  // state and stabilisation timer
  // ----------------------------------------------------------------
  hms_regs_type q;
  hms_regs_type d;
  logic stabStart;
  logic stabDone;
  logic wakeTimed;
  logic wakeFull;

  hms_stab_timer u_stab (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(stabStart),
    .longSel(q.stabLong),
    .busy(),
    .done(stabDone)
  );

  // timebase line only in timed mask
  assign wakeTimed = |(irqPend & WAKE_TIMED_MASK);
  assign wakeFull = |(irqPend & WAKE_FULL_MASK);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    stabStart = 1'b0;
    d.ccrMaskWr = 1'b0;
    d.ccrPush = 1'b0;
    d.serviceIrq = 1'b0;
    d.fetchVector = 1'b0;
    d.wdogResetReq = 1'b0;
    d.rdata = REG_READ_ZERO;

    if (!q.captured) begin
      d.captured = 1'b1;
      d.stabLong = stabLongSync;
    end

    // register port, unmapped reads give zero
    if (regWr && regAddr == CLOCK_CTRL_STATUS_REG_OFS) begin
      d.oscIrqEnable = regWdata[OSC_IRQ_ENABLE_BIT];
    end
    if (regRd) begin
      unique case (regAddr)
        CLOCK_CTRL_STATUS_REG_OFS: begin
          d.rdata[OSC_IRQ_ENABLE_BIT] = q.oscIrqEnable;
          d.rdata[STAB_LONG_BIT] = q.stabLong;
        end
        HALT_STATUS_REG_OFS: begin
          d.rdata[STATUS_STATE_LSB +: 4] = q.state;
          d.rdata[STATUS_BY_RESET_BIT] = q.byReset;
        end
        default: d.rdata = REG_READ_ZERO;
      endcase
    end

    unique case (q.state)
      HMS_RUN: begin
        if (rstReqSync) begin
          // reset request while running also takes the start-up wait
          d.state = HMS_STAB;
          d.byReset = 1'b1;
          stabStart = 1'b1;
        end else if (haltExec) begin
          if (q.oscIrqEnable) begin
            d.state = HMS_TIMED;
            d.ccrMaskWr = 1'b1;
            d.ccrMaskVal = CCR_MASK_HALT;
          end else if (wdogActive && wdogOnHaltOption) begin
            d.wdogResetReq = 1'b1;
          end else begin
            d.state = HMS_FULL;
            d.ccrMaskWr = 1'b1;
            d.ccrMaskVal = CCR_MASK_HALT;
          end
        end
      end
      HMS_TIMED: begin
        if (rstReqSync) begin
          d.state = HMS_STAB;
          d.byReset = 1'b1;
          stabStart = 1'b1;
        end else if (wakeTimed) begin
          d.state = HMS_RUN;
          d.byReset = 1'b0;
          d.serviceIrq = 1'b1;
          d.ccrPush = 1'b1;
          d.ccrMaskWr = 1'b1;
          d.ccrMaskVal = irqPrio;
        end
      end
      HMS_FULL: begin
        if (rstReqSync || wakeFull) begin
          d.state = HMS_STAB;
          d.byReset = rstReqSync;
          stabStart = 1'b1;
        end
      end
      HMS_STAB: begin
        if (stabDone) begin
          d.state = HMS_RUN;
          if (q.byReset) begin
            d.fetchVector = 1'b1;
          end else begin
            d.serviceIrq = 1'b1;
            d.ccrPush = 1'b1;
            d.ccrMaskWr = 1'b1;
            d.ccrMaskVal = irqPrio;
          end
        end
      end
    endcase

    // clock gates follow the next state so they align with it
    // timed keeps osc and timebase
    d.cpuClkEn = (d.state == HMS_RUN);
    d.periphClkEn = (d.state == HMS_RUN);
    d.oscEn = (d.state != HMS_FULL);
    d.timebaseClkEn = (d.state == HMS_RUN) || (d.state == HMS_TIMED);

    // helper count of wait cycles, checked below
    d.stabSeen = (q.state == HMS_STAB) ? q.stabSeen + 13'h0001 : 13'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q <= HMS_REGS_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdata = q.rdata;
  assign cpuClkEn = q.cpuClkEn;
  assign periphClkEn = q.periphClkEn;
  assign oscEn = q.oscEn;
  assign timebaseClkEn = q.timebaseClkEn;
  assign ccrMaskWr = q.ccrMaskWr;
  assign ccrMaskVal = q.ccrMaskVal;
  assign ccrPush = q.ccrPush;
  assign serviceIrq = q.serviceIrq;
  assign fetchResetVector = q.fetchVector;
  assign wdogResetReq = q.wdogResetReq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic [12:0] stabLimit;
  assign stabLimit = q.stabLong ? STAB_LONG_CYC : STAB_SHORT_CYC;

  AST_TIMED_ENTRY: assert property (
    q.state == HMS_RUN && !rstReqSync && haltExec && q.oscIrqEnable
    |=> q.state == HMS_TIMED && timebaseClkEn && !cpuClkEn)
    else $error("timed halt not entered");

  AST_FULL_ENTRY: assert property (
    q.state == HMS_RUN && !rstReqSync && haltExec && !q.oscIrqEnable
    && !(wdogActive && wdogOnHaltOption)
    |=> q.state == HMS_FULL && !oscEn)
    else $error("full halt not entered");

  AST_TIMED_EXIT: assert property (
    q.state == HMS_TIMED && (wakeTimed || rstReqSync)
    |=> q.state != HMS_TIMED)
    else $error("timed halt not left");

  AST_TIMED_NO_WAIT: assert property (
    q.state == HMS_TIMED && wakeTimed && !rstReqSync
    |=> serviceIrq && cpuClkEn && q.state == HMS_RUN)
    else $error("timed halt interrupt exit delayed");

  AST_RESET_WAIT: assert property (
    q.state == HMS_TIMED && rstReqSync
    |=> q.state == HMS_STAB ##1 !fetchResetVector[*8])
    else $error("reset exit skipped start-up wait");

  AST_MASK_FORCE: assert property (
    q.state == HMS_RUN && !rstReqSync && haltExec && $past(q.state) == HMS_RUN
    && !(wdogActive && wdogOnHaltOption && !q.oscIrqEnable)
    |=> ccrMaskWr && ccrMaskVal == CCR_MASK_HALT)
    else $error("mask level not forced on entry");

  AST_PENDING_WAKE: assert property (
    (q.state == HMS_RUN && haltExec && q.oscIrqEnable && !rstReqSync)
    ##1 (wakeTimed && !rstReqSync)
    |=> serviceIrq)
    else $error("pending interrupt did not wake");

  AST_TIMED_CLOCKS: assert property (
    q.state == HMS_TIMED
    |-> oscEn && timebaseClkEn && !periphClkEn && !cpuClkEn)
    else $error("timed halt clock gating wrong");

  AST_NO_WDOG_RESET: assert property (
    q.state == HMS_RUN && haltExec && q.oscIrqEnable
    |=> !wdogResetReq)
    else $error("watchdog reset in timed halt entry");

  AST_FULL_HOLD: assert property (
    q.state == HMS_FULL && !wakeFull && !rstReqSync
    |=> q.state == HMS_FULL)
    else $error("full halt left without wake source");

  AST_WAIT_LENGTH: assert property (
    q.state == HMS_STAB && stabDone
    |-> q.stabSeen == stabLimit - 13'h0001)
    else $error("stabilisation wait length wrong");

  AST_FULL_CLOCKS: assert property (
    q.state == HMS_FULL
    |-> !oscEn && !cpuClkEn && !periphClkEn && !timebaseClkEn)
    else $error("clocks running in full halt");

  AST_WDOG_RESET: assert property (
    q.state == HMS_RUN && !rstReqSync && haltExec && !q.oscIrqEnable
    && wdogActive && wdogOnHaltOption
    |=> wdogResetReq && q.state == HMS_RUN)
    else $error("watchdog reset on halt missing");

  AST_SERVICE_PUSH: assert property (
    serviceIrq |-> ccrPush && ccrMaskWr && ccrMaskVal == $past(irqPrio))
    else $error("service without ccr push and level");

  AST_TIMEBASE_FULL: assert property (
    q.state == HMS_FULL && irqPend[TIMEBASE_IRQ_LINE] && !wakeFull
    && !rstReqSync
    |=> q.state == HMS_FULL)
    else $error("timebase woke full halt");

  AST_WAIT_SELECT: assert property (
    q.captured && $past(q.captured) |-> $stable(q.stabLong))
    else $error("wait length changed after capture");

  AST_TIMED_HOLD: assert property (
    q.state == HMS_TIMED && !wakeTimed && !rstReqSync
    |=> q.state == HMS_TIMED)
    else $error("timed halt left without wake source");

  AST_RUN_CLOCKS: assert property (
    q.state == HMS_RUN
    |-> cpuClkEn && periphClkEn && oscEn && timebaseClkEn)
    else $error("clocks stopped while running");

  AST_STAB_CLOCKS: assert property (
    q.state == HMS_STAB
    |-> oscEn && !cpuClkEn && !periphClkEn)
    else $error("clock gating wrong during oscillator settle");

  AST_STAB_HOLD: assert property (
    q.state == HMS_STAB && !stabDone
    |=> q.state == HMS_STAB)
    else $error("oscillator settle wait cut short");

  AST_FULL_RESET_EXIT: assert property (
    q.state == HMS_FULL && rstReqSync
    |=> q.state == HMS_STAB && oscEn && q.byReset)
    else $error("reset did not leave full halt");

  AST_STAB_RESUME: assert property (
    q.state == HMS_STAB && stabDone && !q.byReset
    |=> serviceIrq && ccrPush && cpuClkEn)
    else $error("settle wait did not resume by service");

  COV_TIMED_WAKE: cover property (
    q.state == HMS_TIMED ##1 serviceIrq);
  COV_FULL_WAKE: cover property (
    q.state == HMS_FULL ##1 q.state == HMS_STAB && !q.byReset);
  COV_WDOG: cover property (wdogResetReq);
  COV_RESET_EXIT: cover property (fetchResetVector);
  COV_FULL_RESET: cover property (
    q.state == HMS_FULL ##1 (q.state == HMS_STAB && q.byReset));

endmodule // hms_sequencer

//--- src/hms_stab_timer.sv
// Purpose: oscillator stabilisation wait of 256 or 4096 cpu cycles
// Assumes: start is a one-cycle pulse, longSel stable while busy
// Notes:   done pulses in the last cycle of the wait
`timescale 1ns/100ps
module hms_stab_timer import hms_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic longSel,
  output logic busy,
  output logic done
);

  // ----------------------------------------------------------------
  // counter state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic running;
    logic [12:0] cnt;
  } hms_timer_type;

  hms_timer_type tim_q;
  hms_timer_type tim_d;
  logic [12:0] limit;

  always_comb begin
    tim_d = tim_q;
    done = 1'b0;
    limit = longSel ? STAB_LONG_CYC : STAB_SHORT_CYC;
    if (start) begin
      tim_d.running = 1'b1;
      tim_d.cnt = 13'h0000;
    end else if (tim_q.running) begin
      if (tim_q.cnt == limit - 13'h0001) begin
        done = 1'b1;
        tim_d.running = 1'b0;
      end else begin
        tim_d.cnt = tim_q.cnt + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tim_q <= '0;
    end else begin
      tim_q <= tim_d;
    end
  end

  assign busy = tim_q.running;

endmodule // hms_stab_timer

//--- src/hms_sync2.sv
// Purpose: two flip-flop synchroniser for one pin
// Assumes: pin is asynchronous to clk_sys
// Notes:   no reset, so a static pin is valid at reset release
`timescale 1ns/100ps
module hms_sync2 import hms_pkg::*; (
  input wire logic clk_sys,
  input wire logic pinIn,
  output logic syncOut
);

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  logic [1:0] stage_q;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    stage_q <= {stage_q[0], pinIn};
  end

  assign syncOut = stage_q[1];

endmodule // hms_sync2

//--- test/hms_cpu_model.sv
// Purpose: cpu core and interrupt controller facing the sequencer
// Assumes: raise is a one-cycle request per line from the bench
// Notes:   lines stay pending until serviced or dropped by clr, like a request latch
`timescale 1ns/100ps
module hms_cpu_model import hms_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [13:0] raise,
  input wire logic clr,
  input wire logic serviceIrq,
  input wire logic ccrMaskWr,
  input wire logic [1:0] ccrMaskVal,
  input wire logic ccrPush,
  output logic [13:0] irqPend,
  output logic [1:0] ccrMask,
  output logic [1:0] stackTop
);
  // ----------------------------------------------------------------
  // pending latch and condition code mask bits
  // ----------------------------------------------------------------
  // service pulse clears the latch; clr drops lines that never wake
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irqPend <= 14'h0000;
      ccrMask <= 2'b11;
      stackTop <= 2'b00;
    end else begin
      irqPend <= ((clr | serviceIrq) ? 14'h0000 : irqPend) | raise;
      if (ccrPush) begin
        stackTop <= ccrMask;
      end
      if (ccrMaskWr) begin
        ccrMask <= ccrMaskVal;
      end
    end
  end
endmodule // hms_cpu_model

//--- test/hms_sequencer_tb_top.sv
// Purpose: self-checking bench of the halt mode sequencer
// Assumes: bench drives inputs by nba at the rising edge
// Notes:   wake counts are worked out from the package figures
`timescale 1ns/100ps
module hms_sequencer_tb_top import hms_pkg::*;;
  typedef struct {logic osc_irq_enable; int line; logic [1:0] prio;} hms_row_type;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, d;
  logic regWr = 1'b0, regRd = 1'b0, haltExec = 1'b0, clr = 1'b0;
  logic [13:0] irqPend, raise = 14'h0000;
  logic [1:0] irqPrio = 2'b00, ccrMask, stackTop, ccrMaskVal;
  logic rstReqPin = 1'b0, stabLongPin = 1'b0;
  logic wdogActive = 1'b0, wdogOnHaltOption = 1'b0;
  logic cpuClkEn, periphClkEn, oscEn, timebaseClkEn, ccrMaskWr;
  logic ccrPush, serviceIrq, fetchResetVector, wdogResetReq;
  int nFail = 0, nTests = 0, n;
  hms_row_type rows [5] = '{'{1'b1, 2, 2'b01}, '{1'b1, 1, 2'b11},
    '{1'b0, 2, 2'b00}, '{1'b0, 12, 2'b10}, '{1'b1, 8, 2'b10}};

  always #20 clk_sys = ~clk_sys;

  hms_sequencer dut (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .haltExec(haltExec), .irqPend(irqPend), .irqPrio(irqPrio),
    .rstReqPin(rstReqPin), .stabLongPin(stabLongPin), .wdogActive(wdogActive),
    .wdogOnHaltOption(wdogOnHaltOption), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .oscEn(oscEn), .timebaseClkEn(timebaseClkEn),
    .ccrMaskWr(ccrMaskWr), .ccrMaskVal(ccrMaskVal), .ccrPush(ccrPush),
    .serviceIrq(serviceIrq), .fetchResetVector(fetchResetVector),
    .wdogResetReq(wdogResetReq));

  hms_cpu_model partner (.clk_sys(clk_sys), .rstn(rstn), .raise(raise),
    .clr(clr), .serviceIrq(serviceIrq), .ccrMaskWr(ccrMaskWr),
    .ccrMaskVal(ccrMaskVal), .ccrPush(ccrPush), .irqPend(irqPend),
    .ccrMask(ccrMask), .stackTop(stackTop));

  // ----------------------------------------------------------------
  // compare, bus and sequence tasks
  // ----------------------------------------------------------------
  task chk1(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask

  task chkN(input int got, input int exp);
    nTests++;
    if (got != exp) begin
      nFail++;
      $display("ERROR %0t: count got %0d exp %0d", $time, got, exp);
    end
  endtask

  task summarize();
    $display("tests %0d failures %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task regWrite(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task regRead(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask

  // pin must be steady two edges before release for the synchroniser
  task doReset(input logic pin);
    @(posedge clk_sys);
    rstn <= 1'b0;
    stabLongPin <= pin;
    wdogActive <= 1'b0;
    wdogOnHaltOption <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
  endtask

  task doHalt(input logic osc_irq_enable);
    regWrite(CLOCK_CTRL_STATUS_REG_OFS, {7'h00, osc_irq_enable});
    @(posedge clk_sys);
    haltExec <= 1'b1;
    @(posedge clk_sys);
    haltExec <= 1'b0;
    #1;
  endtask

  task chkEntry(input logic osc_irq_enable);
    chk1(ccrMaskWr, 1'b1);
    chk8({6'h00, ccrMaskVal}, 8'h02);
    chk1(cpuClkEn | periphClkEn, 1'b0);
    chk1(oscEn, osc_irq_enable);
    chk1(timebaseClkEn, osc_irq_enable);
  endtask

  task raiseLine(input logic [13:0] m);
    @(posedge clk_sys);
    raise <= m;
    clr <= 1'b0;
    @(posedge clk_sys);
    raise <= 14'h0000;
  endtask

  // edges until the resume pulse, bounded
  task waitPulse(input logic byRst, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while ((byRst ? fetchResetVector : serviceIrq) !== 1'b1 && cnt < 5000);
    if (cnt >= 5000) begin
      nFail++;
      $display("ERROR %0t: resume pulse never came", $time);
      summarize();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    doReset(1'b0);
    chk1(cpuClkEn & periphClkEn & oscEn & timebaseClkEn, 1'b1);
    regRead(HALT_STATUS_REG_OFS, d);
    chk8(d, 8'h01);
    @(posedge clk_sys);
    #1;
    chk8(regRdata, REG_READ_ZERO);
    regRead(4'h7, d);
    chk8(d, 8'h00);
    regWrite(HALT_STATUS_REG_OFS, 8'hFF);
    regRead(HALT_STATUS_REG_OFS, d);
    chk8(d, 8'h01);
    regRead(CLOCK_CTRL_STATUS_REG_OFS, d);
    chk8(d, 8'h00);
    $display("test reset and map done");
    for (int i = 0; i < 5; i++) begin
      doHalt(rows[i].osc_irq_enable);
      chkEntry(rows[i].osc_irq_enable);
      @(posedge clk_sys);
      irqPrio <= rows[i].prio;
      raiseLine(14'h0001 << rows[i].line);
      waitPulse(1'b0, n);
      chkN(n, rows[i].osc_irq_enable ? 1 : int'(STAB_SHORT_CYC) + 1);
      chk8({6'h00, ccrMaskVal}, {6'h00, rows[i].prio});
      chk1(ccrPush & cpuClkEn & oscEn & periphClkEn, 1'b1);
      @(posedge clk_sys);
      #1;
      chk8({6'h00, stackTop}, 8'h02);
      chk8({6'h00, ccrMask}, {6'h00, rows[i].prio});
      $display("test row %0d done", i);
    end
    regRead(CLOCK_CTRL_STATUS_REG_OFS, d);
    chk8(d, 8'h01);
    // pending before entry
    raiseLine(14'h0010);
    doHalt(1'b1);
    chkEntry(1'b1);
    waitPulse(1'b0, n);
    chkN(n, 1);
    $display("test pending wake done");
    // lines 0 and 1 must not wake full halt
    doHalt(1'b0);
    chkEntry(1'b0);
    raiseLine(14'h0003);
    repeat (8) @(posedge clk_sys);
    regRead(HALT_STATUS_REG_OFS, d);
    chk8(d, 8'h04);
    @(posedge clk_sys);
    clr <= 1'b1;
    raiseLine(14'h0008);
    waitPulse(1'b0, n);
    chkN(n, int'(STAB_SHORT_CYC) + 1);
    $display("test full refusal done");
    @(posedge clk_sys);
    wdogActive <= 1'b1;
    wdogOnHaltOption <= 1'b1;
    doHalt(1'b0);
    chk1(wdogResetReq, 1'b1);
    regRead(HALT_STATUS_REG_OFS, d);
    chk8(d, 8'h01);
    doHalt(1'b1);
    chk1(wdogResetReq, 1'b0);
    chkEntry(1'b1);
    @(posedge clk_sys);
    rstReqPin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rstReqPin <= 1'b0;
    waitPulse(1'b1, n);
    chkN(n, int'(STAB_SHORT_CYC));
    regRead(HALT_STATUS_REG_OFS, d);
    chk8(d, 8'h11);
    $display("test watchdog and reset wake done");
    doReset(1'b1);
    regRead(CLOCK_CTRL_STATUS_REG_OFS, d);
    chk8(d, 8'h02);
    doHalt(1'b0);
    chkEntry(1'b0);
    raiseLine(14'h1000);
    waitPulse(1'b0, n);
    chkN(n, int'(STAB_LONG_CYC) + 1);
    $display("test long wait done");
    // reset pin wakes full halt, long wait, then vector fetch
    doHalt(1'b0);
    chkEntry(1'b0);
    @(posedge clk_sys);
    rstReqPin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rstReqPin <= 1'b0;
    waitPulse(1'b1, n);
    chkN(n, int'(STAB_LONG_CYC));
    regRead(HALT_STATUS_REG_OFS, d);
    chk8(d, 8'h11);
    $display("test full reset wake done");
    summarize();
  end
endmodule // hms_sequencer_tb_top
